// >>> rtl/adc_seq_pkg.sv
// constants and types shared by the converter sequencer control block
package adc_seq_pkg;
    // register byte offsets
    localparam logic [7:0] CTRL1_OFFS = 8'h00;
    localparam logic [7:0] CTRL2_OFFS = 8'h04;
    localparam logic [7:0] CTRL3_OFFS = 8'h08;
    localparam logic [7:0] MAXCONV_OFFS = 8'h0C;
    localparam logic [7:0] CHSEL_OFFS = 8'h10;
    localparam logic [7:0] CHSEL_LAST_OFFS = 8'h1C;
    localparam logic [7:0] STATUS_OFFS = 8'h20;
    localparam logic [7:0] RESULT_OFFS = 8'h40;
    localparam logic [7:0] MIRROR_OFFS = 8'h80;
    localparam logic [7:0] MIRROR_LAST_OFFS = 8'hBC;
    // control_reg_one fields
    localparam int ACQ_LSB = 0;
    localparam int HALVE_BIT = 4;
    localparam int CONT_BIT = 5;
    localparam int CASC_BIT = 6;
    localparam int OVRD_BIT = 7;
    // control_reg_two fields
    localparam int SOFT1_BIT = 0;
    localparam int SOFT2_BIT = 1;
    localparam int CLR1_BIT = 2;
    localparam int CLR2_BIT = 3;
    localparam int CLRC_BIT = 4;
    localparam int PWM1_EN_BIT = 8;
    localparam int GPIO1_EN_BIT = 9;
    localparam int PWM2_EN_BIT = 10;
    // control_reg_three fields
    localparam int PS_LSB = 0;
    localparam int SMODE_BIT = 4;
    localparam int CLKEN_BIT = 5;
    localparam int ADCPWR_BIT = 6;
    localparam int BGPWR_BIT = 7;
    // conversion_count_reg fields
    localparam int MAX1_LSB = 0;
    localparam int MAX2_LSB = 4;
    // reset values: everything powered down
    localparam logic [7:0] CTRL1_RST = 8'h00;
    localparam logic [2:0] CTRL2_RST = 3'h0;
    localparam logic [7:0] CTRL3_RST = 8'h00;
    localparam logic [6:0] MAXCONV_RST = 7'h00;
    localparam logic [15:0] CHSEL_RST = 16'h0000;
    // timing in converter clock periods; START_DELAY_HALF and SIM_A_LEFT count half periods
    localparam logic [6:0] START_DELAY_HALF = 7'd5;
    localparam logic [6:0] SEQ_RES_BASE = 7'd1;
    localparam logic [6:0] SIM_B_BASE = 7'd5;
    localparam logic [6:0] SEQ_GAP = 7'd1;
    localparam logic [6:0] SIM_GAP = 7'd2;
    localparam logic [6:0] SIM_A_LEFT = 7'd2;
    localparam logic [1:0] RESP_OKAY = 2'b00;
    localparam logic [1:0] RESP_SLVERR = 2'b10;

    typedef enum logic [2:0] {IDLE, DELAY, SAMPLE, GAP, DRAIN} seq_state_e;

    typedef struct packed {
        logic busy;
        logic sim;
        logic [6:0] left;
        logic [3:0] res;
        logic [11:0] a;
        logic [11:0] b;
    } pend_s;
endpackage : adc_seq_pkg

// >>> rtl/adc_sequencer_control.sv
// converter clock, sequencers, result storage and axi4-lite registers
//
// Decided for this implementation: the register addresses and the AXI4-Lite register port.
`timescale 1ns/1ps
module adc_sequencer_control (
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic [7:0] awaddr,
    input wire logic awvalid,
    output logic awready,
    input wire logic [31:0] wdata,
    input wire logic [3:0] wstrb,
    input wire logic wvalid,
    output logic wready,
    output logic [1:0] bresp,
    output logic bvalid,
    input wire logic bready,
    input wire logic [7:0] araddr,
    input wire logic arvalid,
    output logic arready,
    output logic [31:0] rdata,
    output logic [1:0] rresp,
    output logic rvalid,
    input wire logic rready,
    input wire logic pwm_soc_one,
    input wire logic pwm_soc_two,
    input wire logic gpio_soc,
    input wire logic [11:0] input_group_a,
    input wire logic [11:0] input_group_b,
    output logic sample_hold,
    output logic [3:0] channel_select,
    output logic converter_clock,
    output logic converter_power_on,
    output logic bandgap_power_on,
    output logic cascaded_eos_irq,
    output logic seq_one_eos_irq,
    output logic seq_two_eos_irq
);
    import adc_seq_pkg::*;

    logic [7:0] control_reg_one;
    logic [2:0] trig_enable;
    logic [7:0] control_reg_three;
    logic [6:0] conversion_count_reg;
    logic [15:0] slot_channel_select_reg [4];
    logic [11:0] result_mem [16];
    logic [2:0] pwm1_sync, pwm2_sync, gpio_sync;
    logic [11:0] ain_a_s1, ain_a_s2, ain_b_s1, ain_b_s2;
    logic [4:0] div_cnt;
    logic half_tick;
    seq_state_e state;
    logic [6:0] cnt;
    logic cur;
    logic [3:0] ptr1;
    logic [2:0] ptr2;
    logic [3:0] done_cnt;
    logic req1, req2;
    logic pw;
    pend_s pend [2];
    logic wr_go, soft1, soft2, clr1, clr2, clrc;
    logic end_of_sequence;

    wire logic [3:0] acq = control_reg_one[ACQ_LSB +: 4];
    wire logic casc = control_reg_one[CASC_BIT];
    wire logic cont = control_reg_one[CONT_BIT];
    wire logic sim = control_reg_three[SMODE_BIT];
    wire logic clk_en = control_reg_three[CLKEN_BIT];
    wire logic [6:0] acq_half = {2'b00, acq, 1'b0} + 7'd2;
    wire logic [6:0] gap_half = sim ? {SIM_GAP[5:0], 1'b0} : {SEQ_GAP[5:0], 1'b0};
    wire logic [3:0] slot_rel = cur ? {1'b0, ptr2} : ptr1;
    wire logic [3:0] slot_abs = cur ? {1'b1, ptr2} : ptr1;
    wire logic [3:0] last_cnt = casc ? conversion_count_reg[MAX1_LSB +: 4]
        : (cur ? {1'b0, conversion_count_reg[MAX2_LSB +: 3]}
               : {1'b0, conversion_count_reg[MAX1_LSB +: 3]});
    wire logic [3:0] res_base = cur ? 4'h8 : 4'h0;
    wire logic [3:0] slot_field = slot_channel_select_reg[slot_abs[3:2]][slot_abs[1:0]*4 +: 4];

    function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nw,
                                          input logic [3:0] strb);
        logic [31:0] r;
        r = old;
        for (int i = 0; i < 4; i++) begin
            if (strb[i]) begin
                r[i*8 +: 8] = nw[i*8 +: 8];
            end
        end
        return r;
    endfunction : merge

    function automatic logic fell(input logic [2:0] s);
        return s[2] && !s[1];
    endfunction : fell

    // synchronisers for pins and analog data
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            pwm1_sync <= 3'h0;
            pwm2_sync <= 3'h0;
            gpio_sync <= 3'h0;
            ain_a_s1 <= 12'h000;
            ain_a_s2 <= 12'h000;
            ain_b_s1 <= 12'h000;
            ain_b_s2 <= 12'h000;
        end else begin
            pwm1_sync <= {pwm1_sync[1:0], pwm_soc_one};
            pwm2_sync <= {pwm2_sync[1:0], pwm_soc_two};
            gpio_sync <= {gpio_sync[1:0], gpio_soc};
            ain_a_s1 <= input_group_a;
            ain_a_s2 <= ain_a_s1;
            ain_b_s1 <= input_group_b;
            ain_b_s2 <= ain_b_s1;
        end
    end

    // triggers on falling edge; ignored while own sequencer busy
    wire logic busy1 = (state != IDLE) && !cur;
    wire logic busy2 = (state != IDLE) && cur;
    wire logic trig1 = soft1 || (trig_enable[0] && fell(pwm1_sync))
        || (trig_enable[1] && fell(gpio_sync));
    wire logic trig2 = !casc && (soft2 || (trig_enable[2] && fell(pwm2_sync)));
    wire logic grant = (state == IDLE) && clk_en && (req1 || req2);

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            req1 <= 1'b0;
            req2 <= 1'b0;
        end else begin
            req1 <= grant ? 1'b0 : (req1 || (trig1 && !busy1));
            req2 <= (grant && !req1) ? 1'b0 : (req2 || (trig2 && !busy2));
        end
    end

    // converter clock divider in half periods
    wire logic [4:0] half_len = ((control_reg_three[PS_LSB +: 4] == 4'h0) ? 5'd1
        : {1'b0, control_reg_three[PS_LSB +: 4]}) << control_reg_one[HALVE_BIT];
    assign half_tick = clk_en && (div_cnt >= half_len - 5'd1);

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            div_cnt <= 5'd0;
            converter_clock <= 1'b0;
        end else if (!clk_en) begin
            div_cnt <= 5'd0;
            converter_clock <= 1'b0;
        end else if (half_tick) begin
            div_cnt <= 5'd0;
            converter_clock <= !converter_clock;
        end else begin
            div_cnt <= div_cnt + 5'd1;
        end
    end

    // sequencer state machine
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            state <= IDLE;
            cnt <= 7'd0;
            cur <= 1'b0;
            ptr1 <= 4'h0;
            ptr2 <= 3'h0;
            done_cnt <= 4'h0;
            sample_hold <= 1'b0;
            channel_select <= 4'h0;
            pw <= 1'b0;
            end_of_sequence <= 1'b0;
        end else begin
            end_of_sequence <= 1'b0;
            if (grant) begin
                cur <= !req1 && req2;
                done_cnt <= 4'h0;
                state <= DELAY;
                cnt <= START_DELAY_HALF - 7'd1;
            end else if (half_tick) begin
                case (state)
                    DELAY, GAP: begin
                        if (cnt == 7'd0) begin
                            state <= SAMPLE;
                            sample_hold <= 1'b1;
                            channel_select <= sim ? {1'b0, slot_field[2:0]} : slot_field;
                            cnt <= acq_half - 7'd1;
                        end else begin
                            cnt <= cnt - 7'd1;
                        end
                    end
                    SAMPLE: begin
                        if (cnt == 7'd0) begin
                            sample_hold <= 1'b0;
                            pw <= !pw;
                            if (cur) begin
                                ptr2 <= ptr2 + 3'd1;
                            end else begin
                                ptr1 <= casc ? ptr1 + 4'd1 : {1'b0, ptr1[2:0] + 3'd1};
                            end
                            done_cnt <= done_cnt + 4'd1;
                            if (done_cnt == last_cnt) begin
                                state <= DRAIN;
                            end else begin
                                state <= GAP;
                                cnt <= gap_half - 7'd1;
                            end
                        end else begin
                            cnt <= cnt - 7'd1;
                        end
                    end
                    DRAIN: begin
                        if (!pend[0].busy && !pend[1].busy) begin
                            end_of_sequence <= 1'b1;
                            if (!control_reg_one[OVRD_BIT] || !cont) begin
                                ptr1 <= 4'h0;
                                ptr2 <= 3'h0;
                            end
                            done_cnt <= 4'h0;
                            if (cont) begin
                                state <= DELAY;
                                cnt <= START_DELAY_HALF - 7'd1;
                            end else begin
                                state <= IDLE;
                            end
                        end
                    end
                    default: state <= IDLE;
                endcase
            end
        end
    end

    // conversion pipeline and result storage
    wire logic capture = half_tick && (state == SAMPLE) && (cnt == 7'd0);
    wire logic [11:0] seq_pick = slot_field[3] ? ain_b_s2 : ain_a_s2;

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            for (int i = 0; i < 2; i++) begin
                pend[i] <= '0;
            end
            for (int i = 0; i < 16; i++) begin
                result_mem[i] <= 12'h000;
            end
        end else begin
            if (half_tick) begin
                for (int i = 0; i < 2; i++) begin
                    if (pend[i].busy) begin
                        pend[i].left <= pend[i].left - 7'd1;
                        if (pend[i].sim && pend[i].left == SIM_A_LEFT + 7'd1) begin
                            result_mem[pend[i].res] <= pend[i].a;
                        end
                        if (pend[i].left == 7'd1) begin
                            pend[i].busy <= 1'b0;
                            if (pend[i].sim) begin
                                result_mem[pend[i].res + 4'd1] <= pend[i].b;
                            end else begin
                                result_mem[pend[i].res] <= pend[i].a;
                            end
                        end
                    end
                end
            end
            if (capture) begin
                pend[pw].busy <= 1'b1;
                pend[pw].sim <= sim;
                pend[pw].left <= sim ? {2'b00, acq, 1'b0} + {SIM_B_BASE[5:0], 1'b0}
                    : {2'b00, acq, 1'b0} + {SEQ_RES_BASE[5:0], 1'b0};
                pend[pw].res <= sim ? res_base + {slot_rel[2:0], 1'b0} : slot_abs;
                pend[pw].a <= sim ? ain_a_s2 : seq_pick;
                pend[pw].b <= ain_b_s2;
            end
        end
    end

    // end-of-sequence flags, set wins over clear
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            seq_one_eos_irq <= 1'b0;
            seq_two_eos_irq <= 1'b0;
            cascaded_eos_irq <= 1'b0;
        end else begin
            seq_one_eos_irq <= (end_of_sequence && !cur) || (seq_one_eos_irq && !clr1);
            seq_two_eos_irq <= (end_of_sequence && cur) || (seq_two_eos_irq && !clr2);
            cascaded_eos_irq <= (end_of_sequence && casc) || (cascaded_eos_irq && !clrc);
        end
    end

    // axi4-lite write channel
    assign wr_go = awvalid && wvalid && !bvalid;
    assign awready = wr_go;
    assign wready = wr_go;
    wire logic wr_pulse = wr_go && (awaddr == CTRL2_OFFS) && wstrb[0];
    assign soft1 = wr_pulse && wdata[SOFT1_BIT];
    assign soft2 = wr_pulse && wdata[SOFT2_BIT];
    assign clr1 = wr_pulse && wdata[CLR1_BIT];
    assign clr2 = wr_pulse && wdata[CLR2_BIT];
    assign clrc = wr_pulse && wdata[CLRC_BIT];
    assign converter_power_on = control_reg_three[ADCPWR_BIT];
    assign bandgap_power_on = control_reg_three[BGPWR_BIT];

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            control_reg_one <= CTRL1_RST;
            trig_enable <= CTRL2_RST;
            control_reg_three <= CTRL3_RST;
            conversion_count_reg <= MAXCONV_RST;
            for (int i = 0; i < 4; i++) begin
                slot_channel_select_reg[i] <= CHSEL_RST;
            end
            bvalid <= 1'b0;
            bresp <= RESP_OKAY;
        end else begin
            if (bvalid && bready) begin
                bvalid <= 1'b0;
            end
            if (wr_go) begin
                bvalid <= 1'b1;
                bresp <= RESP_OKAY;
                if (awaddr == CTRL1_OFFS) begin
                    control_reg_one <= 8'(merge({24'h0, control_reg_one}, wdata, wstrb));
                end else if (awaddr == CTRL2_OFFS) begin
                    if (wstrb[1]) begin
                        trig_enable <= wdata[PWM2_EN_BIT:PWM1_EN_BIT];
                    end
                end else if (awaddr == CTRL3_OFFS) begin
                    control_reg_three <= 8'(merge({24'h0, control_reg_three}, wdata, wstrb));
                end else if (awaddr == MAXCONV_OFFS) begin
                    conversion_count_reg <= 7'(merge({25'h0, conversion_count_reg}, wdata, wstrb));
                end else if (awaddr >= CHSEL_OFFS && awaddr <= CHSEL_LAST_OFFS) begin
                    slot_channel_select_reg[awaddr[3:2]] <=
                        16'(merge({16'h0, slot_channel_select_reg[awaddr[3:2]]}, wdata, wstrb));
                end else if (awaddr == STATUS_OFFS
                             || (awaddr >= RESULT_OFFS && awaddr <= MIRROR_LAST_OFFS)) begin
                    bresp <= RESP_OKAY;
                end else begin
                    bresp <= RESP_SLVERR;
                end
            end
        end
    end

    // axi4-lite read channel
    assign arready = !rvalid;

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            rvalid <= 1'b0;
            rdata <= 32'h0000_0000;
            rresp <= RESP_OKAY;
        end else if (arvalid && !rvalid) begin
            rvalid <= 1'b1;
            rresp <= RESP_OKAY;
            rdata <= 32'h0000_0000;
            if (araddr == CTRL1_OFFS) begin
                rdata <= {24'h0, control_reg_one};
            end else if (araddr == CTRL2_OFFS) begin
                rdata <= {21'h0, trig_enable, 8'h00};
            end else if (araddr == CTRL3_OFFS) begin
                rdata <= {24'h0, control_reg_three};
            end else if (araddr == MAXCONV_OFFS) begin
                rdata <= {25'h0, conversion_count_reg};
            end else if (araddr >= CHSEL_OFFS && araddr <= CHSEL_LAST_OFFS) begin
                rdata <= {16'h0, slot_channel_select_reg[araddr[3:2]]};
            end else if (araddr == STATUS_OFFS) begin
                rdata <= {24'h0, req2, req1, cur, busy2, busy1, cascaded_eos_irq,
                          seq_two_eos_irq, seq_one_eos_irq};
            end else if (araddr >= RESULT_OFFS && araddr < MIRROR_OFFS) begin
                rdata <= {16'h0, result_mem[araddr[5:2]], 4'h0};
            end else if (araddr >= MIRROR_OFFS && araddr <= MIRROR_LAST_OFFS) begin
                rdata <= {20'h0, result_mem[araddr[5:2]]};
            end else begin
                rresp <= RESP_SLVERR;
            end
        end else if (rvalid && rready) begin
            rvalid <= 1'b0;
        end
    end
endmodule : adc_sequencer_control

// >>> tb/seq_ctrl_assertions.sv
// port timing checker for the converter sequencer control block
`timescale 1ns/1ps
module seq_ctrl_checker (
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic awvalid,
    input wire logic wvalid,
    input wire logic awready,
    input wire logic wready,
    input wire logic bvalid,
    input wire logic bready,
    input wire logic [7:0] araddr,
    input wire logic arvalid,
    input wire logic arready,
    input wire logic [31:0] rdata,
    input wire logic [1:0] rresp,
    input wire logic rvalid,
    input wire logic rready,
    input wire logic sample_hold,
    input wire logic [3:0] channel_select,
    input wire logic converter_power_on,
    input wire logic bandgap_power_on,
    input wire logic seq_one_eos_irq,
    input wire logic cascaded_eos_irq
);
    import adc_seq_pkg::*;
    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn);
    reset_quiet_a: assert property (
        $rose(aresetn) |-> !sample_hold && !converter_power_on && !bandgap_power_on)
        else $error("outputs active right after reset");
    wr_answer_a: assert property (
        awvalid && wvalid && awready |=> bvalid) else $error("write not answered");
    wr_hold_a: assert property (
        bvalid && !bready |=> bvalid) else $error("write response dropped early");
    wr_refuse_a: assert property (
        bvalid |-> !awready && !wready) else $error("write taken while response pending");
    rd_answer_a: assert property (
        arvalid && arready |=> rvalid) else $error("read not answered");
    rd_hold_a: assert property (
        rvalid && !rready |=> rvalid && $stable(rdata) && $stable(rresp))
        else $error("read data not held");
    rd_unmapped_a: assert property (
        arvalid && arready && araddr == 8'h3C |=> rresp == RESP_SLVERR && rdata == 32'h0)
        else $error("unmapped read not refused");
    sh_window_a: assert property (
        $rose(sample_hold) |-> sample_hold [*2] ##[1:999] !sample_hold)
        else $error("sample window length wrong");
    sel_steady_a: assert property (
        sample_hold && $past(sample_hold) |-> $stable(channel_select))
        else $error("channel changed inside sample window");
    cover property ($rose(seq_one_eos_irq));
    cover property ($rose(cascaded_eos_irq));
    cover property (arvalid && arready && araddr == 8'h3C);
endmodule : seq_ctrl_checker

bind adc_sequencer_control seq_ctrl_checker u_chk (.aclk, .aresetn, .awvalid, .wvalid,
    .awready, .wready, .bvalid, .bready, .araddr, .arvalid, .arready, .rdata, .rresp, .rvalid,
    .rready, .sample_hold, .channel_select, .converter_power_on, .bandgap_power_on,
    .seq_one_eos_irq, .cascaded_eos_irq);

// >>> tb/front_end_model.sv
// analog front end and trigger pin model
`timescale 1ns/1ps
module front_end_model (
    input wire logic aclk,
    input wire logic [3:0] channel_select,
    input wire logic [2:0] fire,
    output logic pwm_soc_one,
    output logic pwm_soc_two,
    output logic gpio_soc,
    output logic [11:0] input_group_a,
    output logic [11:0] input_group_b
);
    logic [2:0] low_left [3] = '{3'h0, 3'h0, 3'h0};
    // pins idle high, a fired pin stays low four cycles
    always @(posedge aclk) begin
        for (int i = 0; i < 3; i++) begin
            if (fire[i]) low_left[i] <= 3'h4;
            else if (low_left[i] != 3'h0) low_left[i] <= low_left[i] - 3'h1;
        end
    end
    assign pwm_soc_one = (low_left[0] == 3'h0);
    assign gpio_soc = (low_left[1] == 3'h0);
    assign pwm_soc_two = (low_left[2] == 3'h0);
    // each input reports its group and index
    assign input_group_a = {4'hA, 5'h00, channel_select[2:0]};
    assign input_group_b = {4'hB, 5'h00, channel_select[2:0]};
endmodule : front_end_model

// >>> tb/tb.sv
// self-checking bench for the converter sequencer control block
`timescale 1ns/1ps
module tb;
    import adc_seq_pkg::*;
    typedef struct packed {logic [7:0] a; logic [31:0] d; logic [31:0] q; logic [1:0] r;} row_s;
    logic aclk = 1'b0, aresetn = 1'b0, awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0;
    logic arvalid = 1'b0, rready = 1'b0, awready, wready, bvalid, arready, rvalid;
    logic [7:0] awaddr = 8'h00, araddr = 8'h00;
    logic [31:0] wdata = 32'h0, rdata, rd;
    logic [3:0] wstrb = 4'hF, channel_select;
    logic [1:0] bresp, rresp, rs;
    logic [2:0] fire = 3'h0;
    logic [11:0] input_group_a, input_group_b;
    logic pwm_soc_one, pwm_soc_two, gpio_soc, sample_hold, converter_clock;
    logic converter_power_on, bandgap_power_on, cascaded_eos_irq, seq_one_eos_irq, seq_two_eos_irq;
    int miscompares = 0, compares = 0, cycles = 0, width = 0, pulses = 0, w_exp = 4;
    int toggles = 0;
    logic prev_cc = 1'b0;
    logic [11:0] ev [3] = '{12'hA01, 12'hB02, 12'hA03};
    row_s rows [5] = '{'{CTRL1_OFFS, 32'hA5, 32'hA5, RESP_OKAY},
        '{CTRL3_OFFS, 32'h1F, 32'h1F, RESP_OKAY},
        '{MAXCONV_OFFS, 32'hFFFFFFFF, 32'h7F, RESP_OKAY},
        '{CHSEL_LAST_OFFS, 32'h76543210, 32'h00003210, RESP_OKAY},
        '{8'h3C, 32'h1, 32'h0, RESP_SLVERR}};

    adc_sequencer_control u_dut (.aclk, .aresetn, .awaddr, .awvalid, .awready, .wdata, .wstrb,
        .wvalid, .wready, .bresp, .bvalid, .bready, .araddr, .arvalid, .arready, .rdata,
        .rresp, .rvalid, .rready, .pwm_soc_one, .pwm_soc_two, .gpio_soc, .input_group_a,
        .input_group_b, .sample_hold, .channel_select, .converter_clock, .converter_power_on,
        .bandgap_power_on, .cascaded_eos_irq, .seq_one_eos_irq, .seq_two_eos_irq);
    front_end_model u_fe (.aclk, .channel_select, .fire, .pwm_soc_one, .pwm_soc_two,
        .gpio_soc, .input_group_a, .input_group_b);

    initial begin
        forever #25 aclk = ~aclk;
    end

    task automatic wrap_up();
        if (miscompares == 0 && compares > 0) $display("*** PASS ***");
        else $display("*** FAIL ***");
        $finish;
    endtask : wrap_up

    task automatic chk(input string n, input logic [31:0] s, input logic [31:0] e);
        compares++;
        if (s !== e) begin
            miscompares++;
            $display("unexpected %s expected %h seen %h", n, e, s);
        end
    endtask : chk

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge aclk);
        awaddr <= a;
        wdata <= d;
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        bready <= 1'b1;
        do @(posedge aclk); while (!awready);
        awvalid <= 1'b0;
        wvalid <= 1'b0;
        do @(posedge aclk); while (!bvalid);
        rs = bresp;
        bready <= 1'b0;
    endtask : wr

    task automatic rdr(input logic [7:0] a);
        @(posedge aclk);
        araddr <= a;
        arvalid <= 1'b1;
        rready <= 1'b1;
        do @(posedge aclk); while (!arready);
        arvalid <= 1'b0;
        do @(posedge aclk); while (!rvalid);
        rd = rdata;
        rs = rresp;
        rready <= 1'b0;
    endtask : rdr

    task automatic run(input logic [31:0] t);
        repeat (100) @(posedge aclk);
        pulses = 0;
        wr(CTRL2_OFFS, t);
        wr(CTRL2_OFFS, t);
        repeat (400) @(posedge aclk);
    endtask : run

    // sample pulse width and count, plus hang guard
    always @(negedge aclk) begin
        cycles++;
        if (cycles == 20000) begin
            miscompares++;
            wrap_up();
        end
        if (converter_clock != prev_cc) toggles++;
        prev_cc = converter_clock;
        if (sample_hold) width++;
        else if (width != 0) begin
            chk("hold_width", width, w_exp);
            pulses++;
            width = 0;
        end
    end

    initial begin
        repeat (16) @(posedge aclk);
        chk("power", {29'h0, converter_power_on, bandgap_power_on, sample_hold}, 32'h0);
        chk("reset_clock", {31'h0, converter_clock}, 32'h0);
        aresetn <= 1'b1;
        for (int i = 0; i < 4; i++) begin
            rdr(rows[i].a);
            chk("reset_value", rd, 32'h0);
        end
        for (int i = 0; i < 5; i++) begin
            wr(rows[i].a, rows[i].d);
            chk("bresp", {30'h0, rs}, {30'h0, rows[i].r});
            rdr(rows[i].a);
            chk("rdata", rd, rows[i].q);
            chk("rresp", {30'h0, rs}, {30'h0, rows[i].r});
        end
        wr(CTRL1_OFFS, 32'h01);
        wr(CHSEL_OFFS, 32'h000003A1);
        wr(MAXCONV_OFFS, 32'h02);
        wr(CTRL3_OFFS, 32'hE1);
        run(32'h1);
        chk("pulses", pulses, 3);
        @(posedge aclk);
        toggles = 0;
        repeat (8) @(posedge aclk);
        chk("conv_clock", toggles, 8);
        for (int k = 0; k < 3; k++) begin
            rdr(RESULT_OFFS + 8'(4 * k));
            chk("result", rd, {16'h0, ev[k], 4'h0});
            rdr(MIRROR_OFFS + 8'(4 * k));
            chk("mirror", rd, {20'h0, ev[k]});
        end
        @(negedge aclk);
        chk("seq_one_irq", {31'h0, seq_one_eos_irq}, 32'h1);
        wr(CTRL2_OFFS, 32'h4);
        @(negedge aclk);
        chk("irq_clear", {31'h0, seq_one_eos_irq}, 32'h0);
        wr(CHSEL_OFFS, 32'h000053A4);
        run(32'h1);
        chk("pulses", pulses, 3);
        rdr(RESULT_OFFS);
        chk("restart", rd, 32'h0000A040);
        wr(CTRL1_OFFS, 32'h21);
        run(32'h1);
        chk("continuous_run", {31'h0, pulses > 3}, 32'h1);
        wr(CTRL1_OFFS, 32'h01);
        repeat (100) @(posedge aclk);
        wr(MAXCONV_OFFS, 32'h0);
        wr(CHSEL_OFFS, 32'h2);
        wr(CTRL3_OFFS, 32'hF1);
        run(32'h1);
        chk("sim_pulses", pulses, 1);
        for (int k = 0; k < 2; k++) begin
            rdr(RESULT_OFFS + 8'(4 * k));
            chk("pair", rd, {16'h0, k ? 12'hB02 : 12'hA02, 4'h0});
        end
        for (int i = 0; i < 3; i++) begin
            wr(CTRL2_OFFS, 32'h1C | (32'h100 << i));
            @(posedge aclk);
            fire <= 3'h1 << i;
            @(posedge aclk);
            fire <= 3'h0;
            repeat (400) @(posedge aclk);
            chk("pin_start", {30'h0, seq_two_eos_irq, seq_one_eos_irq}, i == 2 ? 32'h2 : 32'h1);
        end
        wr(CTRL1_OFFS, 32'h51);
        w_exp = 8;
        run(32'h1);
        chk("casc_irq", {31'h0, cascaded_eos_irq}, 32'h1);
        chk("halved", pulses, 1);
        @(posedge aclk);
        toggles = 0;
        repeat (8) @(posedge aclk);
        chk("halved_clock", toggles, 4);
        run(32'h2);
        chk("seq_two_off", pulses, 0);
        wrap_up();
    end
endmodule : tb
